// ---- logic/dvocd_pkg.sv ----
// package of constants for the dual voltage output code decoder
package dvocd_pkg;
    // =========================================
    // output image and channel word layout
    localparam int IMAGE_WORDS = 4096;
    localparam int WORD_W = 16;
    localparam int CODE_W = 10;
    localparam int CODE_MSB = 14;
    localparam int CODE_LSB = 5;
    localparam int SIGN_BIT = 15;
    localparam int CHANNELS = 2;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] FALLBACK_CODE = 10'h000;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    // word index width within the output image
    localparam int IMG_ADDR_W = 12;
    // output update state
    typedef enum logic [1:0] {
        DVOCD_RUN = 2'b01,
        DVOCD_FALLBACK = 2'b10
    } dvocd_state_t;
endpackage

// ---- logic/dvocd_word_store.sv ----
// two-word store holding the latest channel words
`timescale 1ns/1ps
module dvocd_word_store
    import dvocd_pkg::*;
#(
    parameter int WIDTH = WORD_W
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic wr_en_in,
    input wire logic wr_sel_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic [WIDTH-1:0] ch0_out,
    output logic [WIDTH-1:0] ch1_out
);
    if (WIDTH < 1) begin : g_bad_width
        $error("word width must be at least one bit");
    end

    logic [WIDTH-1:0] next_ch0;
    logic [WIDTH-1:0] next_ch1;

    always_comb begin
        next_ch0 = ch0_out;
        next_ch1 = ch1_out;
        if (wr_en_in && !wr_sel_in) begin
            next_ch0 = wr_data_in;
        end else if (wr_en_in && wr_sel_in) begin
            next_ch1 = wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ch0_out <= WORD_RESET;
            ch1_out <= WORD_RESET;
        end else begin
            ch0_out <= next_ch0;
            ch1_out <= next_ch1;
        end
    end
endmodule

// ---- logic/dvocd_top.sv ----
// channel word decode and comms-loss fallback for a two-channel 0-10 V output
// Functional notes
// - channel outputs refresh from words the master wrote through the interface.
// - module uses two adjacent image words, one per channel, by slot.
// - only bits 14 to 5 form the value, giving a ten-bit converter code.
// - word values span 0 to 32736 in steps of 32.
// - sign bit 15 set forces that channel to 0 V.
// - word 32000 gives full-scale 10 V.
// - count equals 3200 times volts, linear.
// - words above 32000 convert with no over-range indication.
// - comms loss sends both channels to fallback until restored.
// - fallback is fixed 0 V on both channels.
// - no user parameters or reflex actions; behaviour fixed.
`timescale 1ns/1ps
module dvocd_top
    import dvocd_pkg::*;
#(
    parameter logic [IMG_ADDR_W-1:0] SLOT_BASE = 12'h000
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic img_wr_in,
    input wire logic [IMG_ADDR_W-1:0] img_addr_in,
    input wire logic [WORD_W-1:0] img_data_in,
    input wire logic comms_ok_in,
    output logic [CODE_W-1:0] ch1_code_out,
    output logic [CODE_W-1:0] ch2_code_out,
    output logic fallback_out
);
    // both channel words must fit inside the image
    if (SLOT_BASE > IMG_ADDR_W'(IMAGE_WORDS - CHANNELS)) begin : g_bad_base
        $error("slot base leaves no room for two words");
    end

    // =========================================
    // comms status synchroniser
    // status comes from another clock; only comms_sync may feed logic
    logic comms_meta;
    logic comms_sync;
    logic next_comms_meta;
    logic next_comms_sync;

    always_comb begin
        next_comms_meta = comms_ok_in;
        next_comms_sync = comms_meta;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            comms_meta <= 1'b0;
            comms_sync <= 1'b0;
        end else begin
            comms_meta <= next_comms_meta;
            comms_sync <= next_comms_sync;
        end
    end

    // =========================================
    // word capture from the output image
    logic hit;
    logic sel;
    logic [WORD_W-1:0] word1;
    logic [WORD_W-1:0] word2;

    // slot base fixed at build time; no register can move it
    always_comb begin
        hit = 1'b0;
        sel = 1'b0;
        if (img_wr_in && img_addr_in == SLOT_BASE) begin
            hit = 1'b1;
        end else if (img_wr_in && img_addr_in == SLOT_BASE + 12'h001) begin
            hit = 1'b1;
            sel = 1'b1;
        end
    end

    dvocd_word_store #(
        .WIDTH(WORD_W)
    ) u_store (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_en_in(hit),
        .wr_sel_in(sel),
        .wr_data_in(img_data_in),
        .ch0_out(word1),
        .ch1_out(word2)
    );

    // =========================================
    // fallback state and code outputs
    dvocd_state_t state;
    dvocd_state_t next_state;
    logic [CODE_W-1:0] next_code1;
    logic [CODE_W-1:0] next_code2;
    logic next_fallback;

    // no saturation or flag: 32736 simply yields code 1023
    function automatic logic [CODE_W-1:0] decode(input logic [WORD_W-1:0] w);
        if (w[SIGN_BIT]) begin
            decode = FALLBACK_CODE;
        end else begin
            decode = w[CODE_MSB:CODE_LSB];
        end
    endfunction

    always_comb begin
        next_state = state;
        case (state)
            DVOCD_RUN: begin
                if (!comms_sync) begin
                    next_state = DVOCD_FALLBACK;
                end
            end
            DVOCD_FALLBACK: begin
                if (comms_sync) begin
                    next_state = DVOCD_RUN;
                end
            end
            default: next_state = DVOCD_FALLBACK;
        endcase
        if (next_state == DVOCD_RUN) begin
            next_code1 = decode(word1);
            next_code2 = decode(word2);
            next_fallback = 1'b0;
        end else begin
            next_code1 = FALLBACK_CODE;
            next_code2 = FALLBACK_CODE;
            next_fallback = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // outputs stay at 0 V until comms have been seen once
            state <= DVOCD_FALLBACK;
            ch1_code_out <= CODE_RESET;
            ch2_code_out <= CODE_RESET;
            fallback_out <= 1'b1;
        end else begin
            state <= next_state;
            ch1_code_out <= next_code1;
            ch2_code_out <= next_code2;
            fallback_out <= next_fallback;
        end
    end

    // =========================================
    // checks
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_comms_lost;
        !comms_sync ##1 1'b1;
    endsequence

    // comms back after at least one cycle down
    sequence s_comms_back;
        !comms_sync ##1 comms_sync;
    endsequence

    sequence s_ch1_write;
        img_wr_in && img_addr_in == SLOT_BASE && !img_data_in[15];
    endsequence

    sequence s_ch2_write;
        img_wr_in && img_addr_in == SLOT_BASE + 12'h001 && !img_data_in[15];
    endsequence

    // fallback entry and exit
    a_fallback_zero: assert property (fallback_out |->
        ch1_code_out == 10'h000 && ch2_code_out == 10'h000)
        else $error("fallback code not zero");
    a_loss_enters: assert property (s_comms_lost |-> fallback_out)
        else $error("comms loss did not enter fallback");
    a_restore_leaves: assert property (comms_sync |=> !fallback_out)
        else $error("restored comms did not leave fallback");
    a_run_needs_comms: assert property (!fallback_out |-> $past(comms_sync))
        else $error("left fallback without comms");
    a_resume_latest: assert property (s_comms_back ##0 !word1[15] |=>
        ch1_code_out == $past(word1[14:5]))
        else $error("resume did not use latest word");

    // code decode per channel
    a_sign_zero: assert property (!fallback_out && $past(word1[15])
        && $past(comms_sync) |-> ch1_code_out == 10'h000)
        else $error("sign bit did not force zero");
    a_sign_ch2: assert property (!fallback_out && $past(word2[15])
        && $past(comms_sync) |-> ch2_code_out == 10'h000)
        else $error("channel 2 sign bit did not force zero");
    a_code_ch1: assert property ($past(comms_sync) && !$past(word1[15]) |->
        ch1_code_out == $past(word1[14:5]))
        else $error("channel 1 code mismatch");
    a_code_bits: assert property ($past(comms_sync) && !$past(word2[15]) |->
        ch2_code_out == $past(word2[14:5]))
        else $error("channel 2 code mismatch");
    a_full_scale: assert property ($past(comms_sync) && $past(word1) == 16'h7d00
        |-> ch1_code_out == 10'h3e8)
        else $error("full scale code wrong");
    a_top_code: assert property ($past(comms_sync) && $past(word1) == 16'h7fe0
        |-> ch1_code_out == 10'h3ff)
        else $error("top code wrong");

    // word capture from the image
    a_write_lands: assert property (img_wr_in && img_addr_in == SLOT_BASE |=>
        word1 == $past(img_data_in))
        else $error("channel 1 write lost");
    a_write_ch2: assert property (img_wr_in && img_addr_in == SLOT_BASE + 12'h001
        |=> word2 == $past(img_data_in))
        else $error("channel 2 write lost");
    a_stray_ignored: assert property (img_wr_in && img_addr_in != SLOT_BASE
        && img_addr_in != SLOT_BASE + 12'h001 |=> $stable(word1) && $stable(word2))
        else $error("foreign image word was taken");
    a_idle_holds: assert property (!img_wr_in |=> $stable(word1) && $stable(word2))
        else $error("stored word changed without a write");
    a_ch1_path: assert property (s_ch1_write ##1 comms_sync |=>
        ch1_code_out == $past(img_data_in[14:5], 2))
        else $error("channel 1 write did not reach its code");
    a_ch2_path: assert property (s_ch2_write ##1 comms_sync |=>
        ch2_code_out == $past(img_data_in[14:5], 2))
        else $error("channel 2 write did not reach its code");
endmodule

// ---- tb/dvocd_island_model.sv ----
// island interface model: output image and slot word refresh
`timescale 1ns/1ps
module dvocd_island_model
    import dvocd_pkg::*;
(
    input wire logic clk_in,
    output logic img_wr_out,
    output logic [IMG_ADDR_W-1:0] img_addr_out,
    output logic [WORD_W-1:0] img_data_out
);
    logic [WORD_W-1:0] image [IMAGE_WORDS];
    initial begin
        img_wr_out = 1'b0;
        img_addr_out = 12'h000;
        img_data_out = 16'h0000;
    end
    // =========================================
    // master write lands in the image, then goes out to its slot
    task automatic put(input logic [IMG_ADDR_W-1:0] addr, input logic [WORD_W-1:0] data);
        image[addr] = data;
        @(negedge clk_in);
        img_wr_out = 1'b1;
        img_addr_out = addr;
        img_data_out = image[addr];
        @(negedge clk_in);
        img_wr_out = 1'b0;
        // idle lines never repeat the last word
        img_addr_out = ~addr;
        img_data_out = ~data;
    endtask
endmodule

// ---- tb/dual_voltage_output_code_decoder_test.sv ----
// self-checking bench for the channel word decoder
`timescale 1ns/1ps
module dual_voltage_output_code_decoder_test;
    import dvocd_pkg::*;
    localparam logic [IMG_ADDR_W-1:0] BASE = 12'h123;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic comms_ok_in = 1'b1;
    logic img_wr_in;
    logic [IMG_ADDR_W-1:0] img_addr_in;
    logic [WORD_W-1:0] img_data_in;
    logic [CODE_W-1:0] ch1_code_out;
    logic [CODE_W-1:0] ch2_code_out;
    logic fallback_out;
    int failures = 0;
    int checked = 0;
    int words [2] = '{0, 0};
    int down = 1;
    int edge_words [8] = '{32'h7d00, 32'h801f, 32'h7fe0, 32'h7fff, 32'hffff, 32'h001f,
        32'h0020, 32'h7d20};
    dvocd_island_model island_u (.clk_in(clk_in), .img_wr_out(img_wr_in),
        .img_addr_out(img_addr_in), .img_data_out(img_data_in));
    dvocd_top #(.SLOT_BASE(BASE)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
        .img_wr_in(img_wr_in), .img_addr_in(img_addr_in), .img_data_in(img_data_in),
        .comms_ok_in(comms_ok_in), .ch1_code_out(ch1_code_out),
        .ch2_code_out(ch2_code_out), .fallback_out(fallback_out));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // =========================================
    // reference model and comparisons
    function automatic logic [CODE_W-1:0] model_code(input int w);
        if (down != 0 || w[15]) return 10'h000;
        return 10'((w / 32) % 1024);
    endfunction
    task automatic chk(input string name, input logic [CODE_W-1:0] exp,
        input logic [CODE_W-1:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_all();
        @(negedge clk_in);
        chk("ch1_code_out", model_code(words[0]), ch1_code_out);
        chk("ch2_code_out", model_code(words[1]), ch2_code_out);
        chk("fallback_out", 10'(down), {9'h000, fallback_out});
    endtask
    // ch -1 and 2 are neighbouring slots that must be ignored
    task automatic wr(input int ch, input int w);
        if (ch >= 0 && ch < 2) words[ch] = w;
        island_u.put(BASE + 12'(ch), 16'(w));
        chk_all();
    endtask
    task automatic comms(input logic ok);
        @(negedge clk_in);
        comms_ok_in = ok;
        down = ok ? 0 : 1;
        repeat (2) @(negedge clk_in);
        chk_all();
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // =========================================
    // main sequence and watchdog
    initial begin
        void'($urandom(76273));
        repeat (11) @(negedge clk_in);
        chk_all();
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        down = 0;
        chk_all();
        for (int i = 0; i < 8; i++) begin
            wr(i % 2, edge_words[i]);
        end
        for (int i = 0; i < 40; i++) begin
            wr(int'($urandom_range(3)) - 1, int'($urandom & 32'hffff));
        end
        comms(1'b0);
        wr(0, 32'h4000);
        wr(1, 32'h1234);
        comms(1'b1);
        wr(1, 32'h7d00);
        finish_test();
    end
    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule
